// [logic/sar_adc_consts.svh]
/*
 * constants for the successive-approximation converter sequencer:
 * register byte offsets, field positions, reset values and timing counts.
 * assumes a 25 MHz bus clock and a 32-bit aligned register map.
 */
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH

// register byte offsets
`define ADC_OFF_CTRL      8'h00
`define ADC_OFF_RANGE     8'h04
`define ADC_OFF_STATUS    8'h08
`define ADC_OFF_MASK      8'h0c
`define ADC_OFF_RESULT    8'h10

// control fields
`define ADC_CTRL_START    0
`define ADC_CTRL_STOP     1
`define ADC_CTRL_MODE_LO  2
`define ADC_CTRL_TRIG_LO  4
`define ADC_CTRL_RES8     6
`define ADC_CTRL_IOS      7
`define ADC_CTRL_RST      8'h00

// range fields
`define ADC_RANGE_END_LO  8
`define ADC_RANGE_RST     8'h00

// status bits
`define ADC_ST_DONE       0
`define ADC_ST_OVR        1
`define ADC_ST_BUSY       8

// timing, in nanoseconds, and clock period
`define ADC_CLK_PERIOD_NS 40
`define ADC_CONV_NS       6130
`define ADC_SAMPLE_NS     2000
// least times round up
`define ADC_CONV_CYC   ((`ADC_CONV_NS + `ADC_CLK_PERIOD_NS - 1) / `ADC_CLK_PERIOD_NS)
`define ADC_SAMPLE_CYC ((`ADC_SAMPLE_NS + `ADC_CLK_PERIOD_NS - 1) / `ADC_CLK_PERIOD_NS)

`endif

// [logic/sar_adc_pkg.sv]
/*
 * types shared by the converter sequencer.
 * assumes sar_adc_consts.svh for numeric constants.
 */
`default_nettype none
package sar_adc_pkg;
   typedef enum logic [1:0] {
      MODE_SINGLE1,
      MODE_SINGLE2,
      MODE_CONTINUOUS,
      MODE_INCREMENTAL
   } conv_mode_t;

   typedef enum logic [1:0] {
      TRIG_SOFTWARE,
      TRIG_RELOAD_TIMER,
      TRIG_FREERUN_ZERO,
      TRIG_RESERVED
   } trig_src_t;

   typedef enum {
      ST_IDLE,
      ST_SAMPLE,
      ST_APPROX,
      ST_SETTLE,
      ST_WAIT
   } seq_state_t;
endpackage
`default_nettype wire

// [logic/sar_adc_sequencer.sv]
/*
 * converter sequencer: channel selection, start triggers, sample and
 * successive-approximation control, result and interrupt registers over AXI4-Lite.
 * assumes an external sample-and-hold and comparator; timer events are
 * asynchronous levels from other logic and are synchronised here.
 */
`include "sar_adc_consts.svh"
`default_nettype none
// Overview of operation
// - sample first, then successive approximation
// - whole conversion at least 6.13 us
// - sampling lasts at least 2.0 us
// - resolution selectable, 8 or 10 bits
// - eight channels chosen by software
// - completion raises interrupt when enabled
// - completion can request I/O transfer service
// - result protected while done flag set and interrupt enabled
// - start from software, reload timer, freerun zero
// - single-shot one channel: convert once, stop
// - single-shot range: each channel once, stop
// - continuous one channel: repeat until stopped
// - continuous range: cycle channels until stopped
// - incremental: one conversion per activation
module sar_adc_sequencer (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [7:0]  awaddr,
   // axi4-lite write data
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   // axi4-lite write response
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   // axi4-lite read address
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [7:0]  araddr,
   // axi4-lite read data
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   // timer trigger events
   input  wire logic        reload_timer_out,
   input  wire logic        freerun_zero,
   // analogue front end
   output logic [2:0]       channel_sel,
   output logic             sample_hold,
   output logic [9:0]       dac_code,
   input  wire logic        comparator_hi,
   // interrupt and transfer service
   output logic             irq,
   output logic             intelligent_io_service
);

   ////////////////////////////////////////////////////////////////////////////
   localparam int          CONV_CYC   = `ADC_CONV_CYC;
   localparam int          SAMPLE_CYC = `ADC_SAMPLE_CYC;
   localparam logic [1:0]  OKAY       = 2'h0;
   localparam logic [1:0]  SLVERR     = 2'h2;

   function automatic logic [2:0] next_chan(input logic [2:0] c, input logic [2:0] s,
                                            input logic [2:0] e);
      next_chan = (c == e) ? s : c + 3'h1;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // input synchronisers
   logic [1:0] rt_sync_r, fz_sync_r, cmp_sync_r;
   logic       rt_prev_r, fz_prev_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rt_sync_r  <= 2'h0;
         fz_sync_r  <= 2'h0;
         cmp_sync_r <= 2'h0;
         rt_prev_r  <= 1'b0;
         fz_prev_r  <= 1'b0;
      end else begin
         rt_sync_r  <= {rt_sync_r[0], reload_timer_out};
         fz_sync_r  <= {fz_sync_r[0], freerun_zero};
         cmp_sync_r <= {cmp_sync_r[0], comparator_hi};
         rt_prev_r  <= rt_sync_r[1];
         fz_prev_r  <= fz_sync_r[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register state
   logic [7:0]  ctrl_r, ctrl_nxt;
   logic [2:0]  start_ch_r, start_ch_nxt, end_ch_r, end_ch_nxt;
   logic [1:0]  status_r, status_nxt, mask_r, mask_nxt;
   logic [9:0]  result_r, result_nxt;
   logic [2:0]  result_ch_r, result_ch_nxt;
   logic        sw_start, sw_stop, done_ev, ovr_ev, result_rd;
   logic        aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
   logic [7:0]  awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic        wr_go, busy;
   logic [9:0]  conv_result;
   logic [2:0]  conv_ch;

   sar_adc_pkg::conv_mode_t mode;
   sar_adc_pkg::trig_src_t  trig;
   assign mode = sar_adc_pkg::conv_mode_t'(ctrl_r[`ADC_CTRL_MODE_LO +: 2]);
   assign trig = sar_adc_pkg::trig_src_t'(ctrl_r[`ADC_CTRL_TRIG_LO +: 2]);

   assign awready = !aw_hold_r && !bvalid_r;
   assign wready  = !w_hold_r && !bvalid_r;
   assign arready = !rvalid_r;
   assign wr_go   = (aw_hold_r || (awvalid && awready)) && (w_hold_r || (wvalid && wready));

   always_comb begin
      logic [7:0]  wa;
      logic [31:0] wd;
      logic        hit;
      wa            = aw_hold_r ? awaddr_r : awaddr;
      wd            = w_hold_r ? wdata_r : wdata;
      hit           = 1'b0;
      ctrl_nxt      = ctrl_r;
      start_ch_nxt  = start_ch_r;
      end_ch_nxt    = end_ch_r;
      mask_nxt      = mask_r;
      status_nxt    = status_r;
      result_nxt    = result_r;
      result_ch_nxt = result_ch_r;
      sw_start      = 1'b0;
      sw_stop       = 1'b0;
      result_rd     = 1'b0;
      aw_hold_nxt   = aw_hold_r;
      w_hold_nxt    = w_hold_r;
      awaddr_nxt    = awaddr_r;
      wdata_nxt     = wdata_r;
      bvalid_nxt    = bvalid_r && !bready;
      bresp_nxt     = bresp_r;
      rvalid_nxt    = rvalid_r && !rready;
      rresp_nxt     = rresp_r;
      rdata_nxt     = rdata_r;
      if (awvalid && awready) begin
         aw_hold_nxt = 1'b1;
         awaddr_nxt  = awaddr;
      end
      if (wvalid && wready) begin
         w_hold_nxt = 1'b1;
         wdata_nxt  = wdata;
      end
      // status clears first so a same-cycle event below still sets it
      if (wr_go) begin
         aw_hold_nxt = 1'b0;
         w_hold_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         hit         = 1'b1;
         if (wa == `ADC_OFF_CTRL) begin
            if (wstrb[0]) begin
               ctrl_nxt = wd[7:0] & 8'hfc;
               sw_start = wd[`ADC_CTRL_START];
               sw_stop  = wd[`ADC_CTRL_STOP];
            end
         end else if (wa == `ADC_OFF_RANGE) begin
            if (wstrb[0]) start_ch_nxt = wd[2:0];
            if (wstrb[1]) end_ch_nxt = wd[`ADC_RANGE_END_LO +: 3];
         end else if (wa == `ADC_OFF_STATUS) begin
            if (wstrb[0]) status_nxt = status_r & ~wd[1:0];
         end else if (wa == `ADC_OFF_MASK) begin
            if (wstrb[0]) mask_nxt = wd[1:0];
         end else if (wa != `ADC_OFF_RESULT) begin
            hit = 1'b0;
         end
         bresp_nxt = hit ? OKAY : SLVERR;
      end
      if (arvalid && arready) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = OKAY;
         if (araddr == `ADC_OFF_CTRL) begin
            rdata_nxt = {24'h0, ctrl_r};
         end else if (araddr == `ADC_OFF_RANGE) begin
            rdata_nxt = {21'h0, end_ch_r, 5'h0, start_ch_r};
         end else if (araddr == `ADC_OFF_STATUS) begin
            rdata_nxt = {23'h0, busy, 6'h0, status_r};
         end else if (araddr == `ADC_OFF_MASK) begin
            rdata_nxt = {30'h0, mask_r};
         end else if (araddr == `ADC_OFF_RESULT) begin
            rdata_nxt = {13'h0, result_ch_r, 6'h0, result_r};
            result_rd = 1'b1;
         end else begin
            rdata_nxt = 32'h0;
            rresp_nxt = SLVERR;
         end
      end
      // protection: a fresh result is dropped while the done flag is set and enabled, unless the result is read that cycle
      if (done_ev) begin
         if (status_r[`ADC_ST_DONE] && mask_r[`ADC_ST_DONE] && !result_rd) begin
            ovr_ev = 1'b1;
         end else begin
            ovr_ev        = 1'b0;
            result_nxt    = conv_result;
            result_ch_nxt = conv_ch;
         end
         status_nxt[`ADC_ST_DONE] = 1'b1;
      end else begin
         ovr_ev = 1'b0;
      end
      if (ovr_ev) status_nxt[`ADC_ST_OVR] = 1'b1;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r      <= `ADC_CTRL_RST;
         start_ch_r  <= 3'h0;
         end_ch_r    <= 3'h0;
         mask_r      <= 2'h0;
         status_r    <= 2'h0;
         result_r    <= 10'h000;
         result_ch_r <= 3'h0;
         aw_hold_r   <= 1'b0;
         w_hold_r    <= 1'b0;
         awaddr_r    <= 8'h00;
         wdata_r     <= 32'h0;
         bvalid_r    <= 1'b0;
         bresp_r     <= 2'h0;
         rvalid_r    <= 1'b0;
         rresp_r     <= 2'h0;
         rdata_r     <= 32'h0;
      end else begin
         ctrl_r      <= ctrl_nxt;
         start_ch_r  <= start_ch_nxt;
         end_ch_r    <= end_ch_nxt;
         mask_r      <= mask_nxt;
         status_r    <= status_nxt;
         result_r    <= result_nxt;
         result_ch_r <= result_ch_nxt;
         aw_hold_r   <= aw_hold_nxt;
         w_hold_r    <= w_hold_nxt;
         awaddr_r    <= awaddr_nxt;
         wdata_r     <= wdata_nxt;
         bvalid_r    <= bvalid_nxt;
         bresp_r     <= bresp_nxt;
         rvalid_r    <= rvalid_nxt;
         rresp_r     <= rresp_nxt;
         rdata_r     <= rdata_nxt;
      end
   end

   assign bvalid = bvalid_r;
   assign bresp  = bresp_r;
   assign rvalid = rvalid_r;
   assign rresp  = rresp_r;
   assign rdata  = rdata_r;
   assign irq    = |(status_r & mask_r);
   // transfer service request follows the done flag when the service is enabled
   assign intelligent_io_service = status_r[`ADC_ST_DONE] && ctrl_r[`ADC_CTRL_IOS];

   ////////////////////////////////////////////////////////////////////////////
   // conversion sequencer
   sar_adc_pkg::seq_state_t state_r, state_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic [3:0] bit_r, bit_nxt;
   logic [9:0] sar_r, sar_nxt;
   logic [2:0] ch_r, ch_nxt;
   logic       trig_ev;

   always_comb begin
      case (trig)
         sar_adc_pkg::TRIG_SOFTWARE:     trig_ev = sw_start;
         sar_adc_pkg::TRIG_RELOAD_TIMER: trig_ev = rt_sync_r[1] && !rt_prev_r;
         sar_adc_pkg::TRIG_FREERUN_ZERO: trig_ev = fz_sync_r[1] && !fz_prev_r;
         default:                        trig_ev = 1'b0;
      endcase
   end

   assign busy        = (state_r != sar_adc_pkg::ST_IDLE);
   assign conv_result = ctrl_r[`ADC_CTRL_RES8] ? {2'h0, sar_r[9:2]} : sar_r;
   assign conv_ch     = ch_r;
   assign done_ev     = (state_r == sar_adc_pkg::ST_SETTLE) && (cnt_r == 8'h00);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = (cnt_r != 8'h00) ? cnt_r - 8'h01 : 8'h00;
      bit_nxt   = bit_r;
      sar_nxt   = sar_r;
      ch_nxt    = ch_r;
      case (state_r)
         sar_adc_pkg::ST_IDLE: begin
            if (trig_ev) begin
               state_nxt = sar_adc_pkg::ST_SAMPLE;
               ch_nxt    = start_ch_r;
               cnt_nxt   = 8'(SAMPLE_CYC - 1);
            end
         end
         sar_adc_pkg::ST_SAMPLE: begin
            if (cnt_r == 8'h00) begin
               state_nxt = sar_adc_pkg::ST_APPROX;
               bit_nxt   = 4'h9;
               sar_nxt   = 10'h200;
               cnt_nxt   = 8'h02; // first trial also waits out the comparator sync
            end
         end
         sar_adc_pkg::ST_APPROX: begin
            // trial bit kept when the input is above the trial code
            if (!cmp_sync_r[1]) sar_nxt[bit_r] = 1'b0;
            if (bit_r != 4'h0 && !(ctrl_r[`ADC_CTRL_RES8] && bit_r == 4'h2)) begin
               bit_nxt               = bit_r - 4'h1;
               sar_nxt[bit_r - 4'h1] = 1'b1;
               cnt_nxt               = 8'h02; // comparator path has two sync stages
            end else begin
               state_nxt = sar_adc_pkg::ST_SETTLE;
               cnt_nxt   = 8'h00;
            end
            if (cnt_r != 8'h00) begin
               state_nxt = state_r;
               bit_nxt   = bit_r;
               sar_nxt   = sar_r;
               cnt_nxt   = cnt_r - 8'h01;
            end
         end
         sar_adc_pkg::ST_SETTLE: begin
            // pad out to the full conversion time
            if (cnt_r == 8'h00) begin
               ch_nxt = next_chan(ch_r, start_ch_r, end_ch_r);
               if (mode == sar_adc_pkg::MODE_CONTINUOUS) begin
                  state_nxt = sar_adc_pkg::ST_SAMPLE;
                  cnt_nxt   = 8'(SAMPLE_CYC - 1);
               end else if (mode == sar_adc_pkg::MODE_INCREMENTAL) begin
                  state_nxt = sar_adc_pkg::ST_WAIT;
               end else if (ch_r == end_ch_r) begin
                  state_nxt = sar_adc_pkg::ST_IDLE;
               end else begin
                  state_nxt = sar_adc_pkg::ST_SAMPLE;
                  cnt_nxt   = 8'(SAMPLE_CYC - 1);
               end
            end
         end
         sar_adc_pkg::ST_WAIT: begin
            if (trig_ev) begin
               state_nxt = sar_adc_pkg::ST_SAMPLE;
               cnt_nxt   = 8'(SAMPLE_CYC - 1);
            end
         end
         default: state_nxt = sar_adc_pkg::ST_IDLE;
      endcase
      // entering settle loads the padding; settle lasts one cycle more than its count
      if (state_r == sar_adc_pkg::ST_APPROX && state_nxt == sar_adc_pkg::ST_SETTLE) begin
         cnt_nxt = 8'(CONV_CYC - SAMPLE_CYC - 1 - (ctrl_r[`ADC_CTRL_RES8] ? 24 : 30));
      end
      if (sw_stop) state_nxt = sar_adc_pkg::ST_IDLE;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= sar_adc_pkg::ST_IDLE;
         cnt_r   <= 8'h00;
         bit_r   <= 4'h0;
         sar_r   <= 10'h000;
         ch_r    <= 3'h0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         bit_r   <= bit_nxt;
         sar_r   <= sar_nxt;
         ch_r    <= ch_nxt;
      end
   end

   assign channel_sel = ch_r;
   assign sample_hold = (state_r == sar_adc_pkg::ST_SAMPLE);
   assign dac_code    = sar_r;

endmodule
`default_nettype wire

// [bench/sar_adc_sequencer_sva.sv]
/*
 * checker for the converter sequencer: bus handshakes, sample and conversion timing.
 * assumes a bind to sar_adc_sequencer; one clock, synchronous active-low reset.
 */
`default_nettype none
module sar_adc_sequencer_chk (
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // register bus
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [7:0]  araddr,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp,
   // front end
   input wire logic [2:0]  channel_sel,
   input wire logic        sample_hold,
   input wire logic [9:0]  dac_code
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] hold_cnt_r;
   logic [7:0] hold_cnt_nxt;
   logic [7:0] gap_r;
   logic [7:0] gap_nxt;
   ////////////////////////////////////////////////////////////
   // gap saturates so a long idle never wraps into a short one
   always_comb begin
      hold_cnt_nxt = sample_hold ? hold_cnt_r + 8'h01 : 8'h00;
      gap_nxt = (gap_r == 8'hff) ? gap_r : gap_r + 8'h01;
      if (sample_hold && hold_cnt_r == 8'h00)
         gap_nxt = 8'h01;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_cnt_r <= 8'h00;
         gap_r <= 8'hff;
      end else begin
         hold_cnt_r <= hold_cnt_nxt;
         gap_r <= gap_nxt;
      end
   end
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_sample_len: assert property ($fell(sample_hold) |-> hold_cnt_r == 8'h32)
      else $error("sampling phase length wrong");
   chk_conv_gap: assert property (sample_hold && hold_cnt_r == 8'h00 |-> gap_r >= 8'h9a)
      else $error("conversions closer than the minimum time");
   chk_approx_start: assert property ($fell(sample_hold) |-> ##[0:1] dac_code == 10'h200)
      else $error("approximation does not start at the midscale trial");
   chk_chan_hold: assert property (sample_hold && !$rose(sample_hold) |-> $stable(channel_sel))
      else $error("channel changed while sampling");
   chk_b_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid)
      else $error("write response late");
   chk_b_once: assert property (bvalid && bready |=> !bvalid)
      else $error("write response repeated");
   chk_r_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read data late");
   chk_r_once: assert property (rvalid && rready |=> !rvalid)
      else $error("read data repeated");
   chk_ar_block: assert property (rvalid |-> !arready)
      else $error("read address taken while data pending");
   chk_slverr_read: assert property (arvalid && arready && araddr >= 8'h14 |=> rresp == 2'h2 && rdata == 32'h0)
      else $error("unmapped read not refused");
endmodule
`default_nettype wire

// [bench/sar_adc_front_model.sv]
/*
 * analogue front-end model: one fixed level per channel and a comparator.
 * assumes levels held for whole conversions; reads the selected channel.
 */
`default_nettype none
module sar_adc_front_model (
   // levels, ten bits per channel, channel 0 lowest
   input  wire logic [79:0] levels,
   // converter side
   input  wire logic [2:0]  channel_sel,
   input  wire logic [9:0]  dac_code,
   output logic             comparator_hi
);
   timeunit 1ns;
   timeprecision 1ns;
   // level sits half a step above its code, so ties never occur
   assign comparator_hi = {levels[channel_sel * 10 +: 10], 1'b1} > {dac_code, 1'b0};
endmodule
`default_nettype wire

// [bench/sar_adc_sequencer_bench.sv]
/*
 * bench for the converter sequencer: bus tasks, mode, trigger and interrupt sequences.
 * assumes the front-end model and the checker files compiled before it.
 */
`include "sar_adc_consts.svh"
`default_nettype none
module sar_adc_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [3:0]  wstrb = 4'hf;
   logic [1:0]  bresp, rresp, resp;
   logic        awready, wready, bvalid, arready, rvalid, comparator_hi, sample_hold, irq;
   logic        reload_timer_out = 1'b0, freerun_zero = 1'b0, intelligent_io_service, sh_d = 1'b0;
   logic [2:0]  channel_sel;
   logic [9:0]  dac_code;
   logic [2:0]  seen[$];
   logic [79:0] levels = {10'h37c, 10'h0c3, 10'h1fe, 10'h201, 10'h2aa, 10'h155, 10'h000, 10'h3ff};
   int          fail_count = 0, compares = 0;
   always #20 aclk = ~aclk;
   sar_adc_sequencer dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
      .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
      .reload_timer_out, .freerun_zero, .channel_sel, .sample_hold, .dac_code, .comparator_hi,
      .irq, .intelligent_io_service);
   sar_adc_front_model front (.levels(levels), .channel_sel, .dac_code, .comparator_hi);
   // channel of every sampling phase, in order
   always @(posedge aclk) begin
      sh_d <= sample_hold;
      if (sample_hold && !sh_d)
         seen.push_back(channel_sel);
   end
   ////////////////////////////////////////////////////////////
   task automatic conclude;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_up;
      cmp(32'h0, 32'h1);
      conclude();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic ta, tw, tb;
      n = 0;
      tb = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!tb) begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         resp = bresp;
         @(posedge aclk);
         if (ta)
            awvalid <= 1'b0;
         if (tw)
            wvalid <= 1'b0;
         if (++n > 50)
            give_up();
      end
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd_reg(input logic [7:0] a);
      int n;
      logic ta, tr;
      n = 0;
      tr = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!tr) begin
         @(negedge aclk);
         ta = arvalid && arready;
         tr = rvalid;
         rd = rdata;
         resp = rresp;
         @(posedge aclk);
         if (ta)
            arvalid <= 1'b0;
         if (++n > 50)
            give_up();
      end
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic wait_bit(input int b, input logic v);
      int n;
      n = 0;
      do begin
         rd_reg(`ADC_OFF_STATUS);
         if (++n > 400)
            give_up();
      end while (rd[b] !== v);
   endtask
   task automatic pins(input logic ei, input logic es);
      @(negedge aclk);
      cmp({31'h0, irq}, {31'h0, ei});
      cmp({31'h0, intelligent_io_service}, {31'h0, es});
      @(posedge aclk);
   endtask
   task automatic pulse(input logic zero);
      if (zero)
         freerun_zero <= 1'b1;
      else
         reload_timer_out <= 1'b1;
      repeat (4) @(posedge aclk);
      freerun_zero <= 1'b0;
      reload_timer_out <= 1'b0;
      repeat (8) @(posedge aclk);
   endtask
   // channels seen must step start..end, wrapping modulo eight
   task automatic check_seq(input logic [2:0] st, input logic [2:0] en, input int cnt);
      logic [2:0] d;
      d = en - st;
      cmp(seen.size(), cnt);
      for (int i = 0; i < cnt; i++)
         cmp({29'h0, seen[i]}, {29'h0, 3'(st + i % (d + 1))});
   endtask
   function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] t, input logic r8, input logic ios,
                                       input logic go);
      ctl = 32'h0;
      ctl[`ADC_CTRL_START] = go;
      ctl[`ADC_CTRL_MODE_LO +: 2] = m;
      ctl[`ADC_CTRL_TRIG_LO +: 2] = t;
      ctl[`ADC_CTRL_RES8] = r8;
      ctl[`ADC_CTRL_IOS] = ios;
   endfunction
   function automatic logic [31:0] res(input logic [2:0] c, input logic r8);
      logic [9:0] v;
      v = levels[c * 10 +: 10];
      res = {13'h0, c, 6'h0, r8 ? {2'b00, v[9:2]} : v};
   endfunction
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         rd_reg(8'(4 * i));
         cmp(rd, 32'h0);
      end
      rd_reg(8'h20);
      cmp({30'h0, resp}, 32'h2);
      cmp(rd, 32'h0);
      wr(8'h20, 32'h1);
      cmp({30'h0, resp}, 32'h2);
      // one channel, software start, interrupt enabled
      wr(`ADC_OFF_MASK, 32'h1);
      wr(`ADC_OFF_RANGE, 32'h0303);
      wr(`ADC_OFF_CTRL, ctl(sar_adc_pkg::MODE_SINGLE1, sar_adc_pkg::TRIG_SOFTWARE, 1'b0, 1'b0, 1'b1));
      wait_bit(`ADC_ST_BUSY, 1'b0);
      rd_reg(`ADC_OFF_RESULT);
      cmp(rd, res(3'h3, 1'b0));
      check_seq(3'h3, 3'h3, 1);
      pins(1'b1, 1'b0);
      // result, though read, must survive a second conversion while done is still set
      seen.delete();
      wr(`ADC_OFF_RANGE, 32'h0505);
      wr(`ADC_OFF_CTRL, ctl(sar_adc_pkg::MODE_SINGLE1, sar_adc_pkg::TRIG_SOFTWARE, 1'b0, 1'b0, 1'b1));
      wait_bit(`ADC_ST_BUSY, 1'b0);
      rd_reg(`ADC_OFF_STATUS);
      cmp(rd, 32'h3);
      rd_reg(`ADC_OFF_RESULT);
      cmp(rd, res(3'h3, 1'b0));
      wr(`ADC_OFF_STATUS, 32'h3);
      pins(1'b0, 1'b0);
      wr(`ADC_OFF_MASK, 32'h0);
      // scanned range, single shot
      seen.delete();
      wr(`ADC_OFF_RANGE, 32'h0301);
      wr(`ADC_OFF_CTRL, ctl(sar_adc_pkg::MODE_SINGLE2, sar_adc_pkg::TRIG_SOFTWARE, 1'b0, 1'b0, 1'b1));
      wait_bit(`ADC_ST_BUSY, 1'b0);
      repeat (300) @(posedge aclk);
      check_seq(3'h1, 3'h3, 3);
      // continuous: one channel, then a range that wraps
      for (int k = 0; k < 2; k++) begin
         seen.delete();
         wr(`ADC_OFF_RANGE, k ? 32'h0106 : 32'h0202);
         wr(`ADC_OFF_CTRL, ctl(sar_adc_pkg::MODE_CONTINUOUS, sar_adc_pkg::TRIG_SOFTWARE, 1'b0, 1'b0, 1'b1));
         for (int n = 0; seen.size() < 5 || sample_hold; n++) begin
            @(posedge aclk);
            if (n > 2000)
               give_up();
         end
         wr(`ADC_OFF_CTRL, 32'h2);
         wait_bit(`ADC_ST_BUSY, 1'b0);
         // an aborted conversion leaves no spacing; wait out the minimum before the next start
         repeat (160) @(posedge aclk);
         check_seq(k ? 3'h6 : 3'h2, k ? 3'h1 : 3'h2, 5);
      end
      // incremental, reload timer edges
      wr(`ADC_OFF_STATUS, 32'h3);
      seen.delete();
      wr(`ADC_OFF_RANGE, 32'h0302);
      wr(`ADC_OFF_CTRL, ctl(sar_adc_pkg::MODE_INCREMENTAL, sar_adc_pkg::TRIG_RELOAD_TIMER, 1'b0, 1'b0, 1'b0));
      for (int i = 0; i < 3; i++) begin
         pulse(1'b0);
         wait_bit(`ADC_ST_DONE, 1'b1);
         wr(`ADC_OFF_STATUS, 32'h3);
      end
      repeat (300) @(posedge aclk);
      check_seq(3'h2, 3'h3, 3);
      // free-running timer zero, 8-bit, transfer service
      wr(`ADC_OFF_CTRL, 32'h2);
      wr(`ADC_OFF_RANGE, 32'h0404);
      wr(`ADC_OFF_CTRL, ctl(sar_adc_pkg::MODE_SINGLE2, sar_adc_pkg::TRIG_FREERUN_ZERO, 1'b1, 1'b1, 1'b0));
      pulse(1'b1);
      wait_bit(`ADC_ST_DONE, 1'b1);
      rd_reg(`ADC_OFF_RESULT);
      cmp(rd, res(3'h4, 1'b1));
      pins(1'b0, 1'b1);
      conclude();
   end
endmodule
bind sar_adc_sequencer sar_adc_sequencer_chk chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
   .bvalid, .bready, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .channel_sel,
   .sample_hold, .dac_code);
`default_nettype wire
